// File: design/dbrt_map.vh
// Register map, reset values and timing constants of the display housekeeping block
`ifndef DBRT_MAP_VH
`define DBRT_MAP_VH
`define DBRT_ADDR_CONTRAST 10'h023
`define DBRT_ADDR_OPER_LVL 10'h024
`define DBRT_ADDR_STBY_DLY 10'h2ea
`define DBRT_ADDR_STBY_LVL 10'h2eb
`define DBRT_ADDR_FW_REL 10'h2ee
`define DBRT_ADDR_SERIAL 10'h2f2
`define DBRT_RST_CONTRAST 4'h5
`define DBRT_RST_OPER_LVL 4'h6
`define DBRT_RST_STBY_DLY 14'h0384
`define DBRT_RST_STBY_LVL 4'h0
`define DBRT_LVL_MAX 4'h9
`define DBRT_LVL_MIN 4'h0
`define DBRT_DLY_MIN 14'h003c
`define DBRT_DLY_MAX 14'h270f
`define DBRT_CLK_HZ 125000000
`define DBRT_TICK_CYCLES (`DBRT_CLK_HZ * 1)
`define DBRT_SEC_PER_TENTH_HR 12'h168
`define DBRT_SEC_LIMIT 32'h000f423f
`define DBRT_TENTHS_MAX 20'hf423f
`define DBRT_ROT_STEPS 3'h6
`endif

// File: design/dbrt_top.v
// Display backlight, contrast, run-time counters and rotation indicator
`include "dbrt_map.vh"
module dbrt_top #(
  parameter TICK_CYCLES = `DBRT_TICK_CYCLES,
  parameter [15:0] FW_RELEASE = 16'h0064,
  parameter [31:0] UNIT_SERIAL = 32'h000186a0
)(
  input wire sys_clk,
  input wire rst_n,
  input wire [2:0] buttonIn,
  input wire identifyReq,
  input wire measuringActive,
  input wire [5:0] compViolation,
  input wire compRunClear,
  input wire [1:0] phaseSeq,
  input wire [2:0] timeSelect,
  input wire regWrite,
  input wire [9:0] regAddr,
  input wire [31:0] regWdata,
  output reg [31:0] regRdata_r,
  output reg [3:0] lcdContrast_r,
  output reg [3:0] backlightLevel_r,
  output reg [19:0] timeValue_r,
  output reg timeInHours_r,
  output reg [1:0] rotationDir_r,
  output reg [2:0] rotationPos_r
);
  // phaseSeq: 01 right-hand, 10 left-hand, other undetermined
  localparam [1:0] ROT_RIGHT = 2'h1;
  localparam [1:0] ROT_LEFT = 2'h2;
  localparam [1:0] ROT_NONE = 2'h0;
  localparam [1:0] BL_OPER = 2'h0;
  localparam [1:0] BL_STBY = 2'h1;
  localparam [1:0] BL_FLASH = 2'h2;

  reg rstSync1_r, rstSync2_r;
  wire rstN = rstSync2_r;
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end
    else
    begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end

  // Two-stage synchronisers for all external level inputs except regWrite, regAddr and regWdata
  localparam SW = 17;
  wire [SW-1:0] asyncIn = {buttonIn, identifyReq, measuringActive, compViolation,
    compRunClear, phaseSeq, timeSelect};
  reg [SW-1:0] syncA_r, syncB_r;
  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      syncA_r <= {SW{1'b0}};
      syncB_r <= {SW{1'b0}};
    end
    else
    begin
      syncA_r <= asyncIn;
      syncB_r <= syncA_r;
    end
  end
  wire [2:0] btnS = syncB_r[16:14];
  wire identS = syncB_r[13];
  wire measS = syncB_r[12];
  wire [5:0] violS = syncB_r[11:6];
  wire clrS = syncB_r[5];
  wire [1:0] phaseS = syncB_r[4:3];
  wire [2:0] selS = syncB_r[2:0];

  reg [2:0] btnPrev_r;
  reg clrPrev_r;
  wire btnPress = |(btnS & ~btnPrev_r);
  wire clrPulse = clrS & ~clrPrev_r;

  function [3:0] clampLvl;
    input [31:0] v;
    begin
      clampLvl = (v > 32'h9) ? `DBRT_LVL_MAX : v[3:0];
    end
  endfunction

  // One-second tick
  reg [31:0] tickCnt_r;
  reg tick_r;
  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      tickCnt_r <= 32'h0;
      tick_r <= 1'b0;
    end
    else if (tickCnt_r >= TICK_CYCLES - 1)
    begin
      tickCnt_r <= 32'h0;
      tick_r <= 1'b1;
    end
    else
    begin
      tickCnt_r <= tickCnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // Register file
  reg [3:0] operLvl_r, stbyLvl_r;
  reg [13:0] stbyDly_r;
  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      lcdContrast_r <= `DBRT_RST_CONTRAST;
      operLvl_r <= `DBRT_RST_OPER_LVL;
      stbyLvl_r <= `DBRT_RST_STBY_LVL;
      stbyDly_r <= `DBRT_RST_STBY_DLY;
    end
    else if (regWrite)
    begin
      case (regAddr)
        `DBRT_ADDR_CONTRAST: lcdContrast_r <= clampLvl(regWdata);
        `DBRT_ADDR_OPER_LVL: operLvl_r <= clampLvl(regWdata);
        `DBRT_ADDR_STBY_LVL: stbyLvl_r <= clampLvl(regWdata);
        `DBRT_ADDR_STBY_DLY:
        begin
          if (regWdata < {18'h0, `DBRT_DLY_MIN})
            stbyDly_r <= `DBRT_DLY_MIN;
          else if (regWdata > {18'h0, `DBRT_DLY_MAX})
            stbyDly_r <= `DBRT_DLY_MAX;
          else
            stbyDly_r <= regWdata[13:0];
        end
        default: ;
      endcase
    end
  end

  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      regRdata_r <= 32'h0;
    else
      case (regAddr)
        `DBRT_ADDR_CONTRAST: regRdata_r <= {28'h0, lcdContrast_r};
        `DBRT_ADDR_OPER_LVL: regRdata_r <= {28'h0, operLvl_r};
        `DBRT_ADDR_STBY_LVL: regRdata_r <= {28'h0, stbyLvl_r};
        `DBRT_ADDR_STBY_DLY: regRdata_r <= {18'h0, stbyDly_r};
        `DBRT_ADDR_FW_REL: regRdata_r <= {16'h0, FW_RELEASE};
        `DBRT_ADDR_SERIAL: regRdata_r <= UNIT_SERIAL;
        default: regRdata_r <= 32'h0;
      endcase
  end

  // Backlight state and inactivity timer
  reg [1:0] blState_r;
  reg [13:0] idleSec_r;
  reg flashPhase_r;
  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      blState_r <= BL_OPER;
      idleSec_r <= 14'h0;
      flashPhase_r <= 1'b0;
      btnPrev_r <= 3'h0;
      clrPrev_r <= 1'b0;
    end
    else
    begin
      btnPrev_r <= btnS;
      clrPrev_r <= clrS;
      if (tick_r)
        flashPhase_r <= ~flashPhase_r;
      if (btnPress)
        idleSec_r <= 14'h0;
      else if (tick_r && idleSec_r < stbyDly_r)
        idleSec_r <= idleSec_r + 14'h1;
      case (blState_r)
        BL_OPER:
          if (identS)
            blState_r <= BL_FLASH;
          else if (!btnPress && idleSec_r >= stbyDly_r)
            blState_r <= BL_STBY;
        BL_STBY:
          if (identS)
            blState_r <= BL_FLASH;
          else if (btnPress)
            blState_r <= BL_OPER;
        BL_FLASH:
          if (!identS)
            blState_r <= BL_OPER;
        default: blState_r <= BL_OPER;
      endcase
    end
  end

  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      backlightLevel_r <= `DBRT_RST_OPER_LVL;
    else
    begin
      case (blState_r)
        BL_OPER: backlightLevel_r <= operLvl_r;
        BL_STBY: backlightLevel_r <= stbyLvl_r;
        BL_FLASH: backlightLevel_r <= flashPhase_r ? `DBRT_LVL_MAX : `DBRT_LVL_MIN;
        default: backlightLevel_r <= operLvl_r;
      endcase
    end
  end

  // Operating hours in tenths; no clear path
  reg [11:0] opSec_r;
  reg [19:0] opTenths_r;
  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      opSec_r <= 12'h0;
      opTenths_r <= 20'h0;
    end
    else if (tick_r && measS)
    begin
      if (opSec_r == `DBRT_SEC_PER_TENTH_HR - 12'h1)
      begin
        opSec_r <= 12'h0;
        if (opTenths_r < `DBRT_TENTHS_MAX)
          opTenths_r <= opTenths_r + 20'h1;
      end
      else
        opSec_r <= opSec_r + 12'h1;
    end
  end

  // Comparator run-time accumulators, seconds
  reg [31:0] compSec_r [0:5];
  integer i;
  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      for (i = 0; i < 6; i = i + 1)
        compSec_r[i] <= 32'h0;
    else if (clrPulse)
      for (i = 0; i < 6; i = i + 1)
        compSec_r[i] <= 32'h0;
    else if (tick_r)
      for (i = 0; i < 6; i = i + 1)
        if (violS[i] && compSec_r[i] != 32'hffffffff)
          compSec_r[i] <= compSec_r[i] + 32'h1;
  end

  // Time display selector
  reg [31:0] selSec;
  reg [31:0] selTenths;
  always @*
  begin
    selSec = 32'h0;
    selTenths = 32'h0;
    if (selS >= 3'h1 && selS <= 3'h6)
    begin
      selSec = compSec_r[selS - 3'h1];
      selTenths = selSec / {20'h0, `DBRT_SEC_PER_TENTH_HR};
    end
  end

  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      timeValue_r <= 20'h0;
      timeInHours_r <= 1'b1;
    end
    else if (selS == 3'h0 || selS == 3'h7)
    begin
      timeValue_r <= opTenths_r;
      timeInHours_r <= 1'b1;
    end
    else if (selSec < `DBRT_SEC_LIMIT)
    begin
      timeValue_r <= selSec[19:0];
      timeInHours_r <= 1'b0;
    end
    else
    begin
      timeValue_r <= (selTenths > {12'h0, `DBRT_TENTHS_MAX}) ?
        `DBRT_TENTHS_MAX : selTenths[19:0];
      timeInHours_r <= 1'b1;
    end
  end

  // Phase-rotation indicator
  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rotationDir_r <= ROT_NONE;
      rotationPos_r <= 3'h0;
    end
    else
    begin
      rotationDir_r <= (phaseS == ROT_RIGHT || phaseS == ROT_LEFT) ? phaseS : ROT_NONE;
      if (tick_r && phaseS == ROT_RIGHT)
        rotationPos_r <= (rotationPos_r == `DBRT_ROT_STEPS - 3'h1) ?
          3'h0 : rotationPos_r + 3'h1;
      else if (tick_r && phaseS == ROT_LEFT)
        rotationPos_r <= (rotationPos_r == 3'h0) ?
          `DBRT_ROT_STEPS - 3'h1 : rotationPos_r - 3'h1;
    end
  end
endmodule // dbrt_top

// File: tb/dbrt_panel_model.sv
// Operator panel model: three push buttons held for a chosen time
module dbrt_panel_model (
  input wire sys_clk,
  output logic [2:0] buttonIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial buttonIn = 3'h0;
  task automatic press(input int idx, input int hold);
    @(posedge sys_clk);
    buttonIn[idx] <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    buttonIn[idx] <= 1'b0;
  endtask
endmodule // dbrt_panel_model

// File: tb/dbrt_top_monitor.sv
// Assertion checker for the display housekeeping top module
module dbrt_top_monitor #(
  parameter [15:0] FW_RELEASE = 16'h0064,
  parameter [31:0] UNIT_SERIAL = 32'h000186a0
)(
  input wire sys_clk,
  input wire rst_n,
  input wire [9:0] regAddr,
  input wire [31:0] regRdata_r,
  input wire [3:0] lcdContrast_r,
  input wire [3:0] backlightLevel_r,
  input wire [19:0] timeValue_r,
  input wire [1:0] rotationDir_r,
  input wire [2:0] rotationPos_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] upCnt;
  // Internal reset lags the pin by two edges
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      upCnt <= 2'h0;
    else if (upCnt != 2'h3)
      upCnt <= upCnt + 2'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  contrast_range_a: assert property (lcdContrast_r <= 4'h9)
    else $error("contrast above nine");
  backlight_range_a: assert property (backlightLevel_r <= 4'h9)
    else $error("backlight above nine");
  time_ceiling_a: assert property (timeValue_r <= 20'hf423f)
    else $error("time display above ceiling");
  rot_code_a: assert property (rotationDir_r != 2'h3)
    else $error("bad rotation code");
  rot_still_a: assert property (rotationDir_r == 2'h0 [*3] |-> $stable(rotationPos_r))
    else $error("indicator moved while undetermined");
  rot_cw_a: assert property (rotationDir_r == 2'h1 && $past(rotationDir_r) == 2'h1
    && $changed(rotationPos_r) |-> rotationPos_r ==
    (($past(rotationPos_r) == 3'h5) ? 3'h0 : $past(rotationPos_r) + 3'h1))
    else $error("clockwise step wrong");
  fw_read_a: assert property (upCnt == 2'h3 && $past(regAddr) == 10'h2ee
    |-> regRdata_r == {16'h0, FW_RELEASE}) else $error("release read wrong");
  serial_read_a: assert property (upCnt == 2'h3 && $past(regAddr) == 10'h2f2
    |-> regRdata_r == UNIT_SERIAL) else $error("serial read wrong");
endmodule // dbrt_top_monitor
bind dbrt_top dbrt_top_monitor #(.FW_RELEASE(FW_RELEASE), .UNIT_SERIAL(UNIT_SERIAL)) mon_u (
  .sys_clk, .rst_n, .regAddr, .regRdata_r, .lcdContrast_r, .backlightLevel_r, .timeValue_r,
  .rotationDir_r, .rotationPos_r);

// File: tb/testbench.sv
// Self-checking bench for the display housekeeping block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;
  logic sys_clk, rst_n, identifyReq, measuringActive, compRunClear, regWrite;
  logic [5:0] compViolation;
  logic [1:0] phaseSeq, rotationDir_r;
  logic [2:0] timeSelect, buttonIn, rotationPos_r;
  logic [9:0] regAddr;
  logic [31:0] regWdata, regRdata_r;
  logic [3:0] lcdContrast_r, backlightLevel_r;
  logic [19:0] timeValue_r;
  logic timeInHours_r;
  int fails = 0, cmpCount = 0, opl = 6, j, n, nine, zero, p0;
  dbrt_top #(.TICK_CYCLES(TICK)) dut_u (.*);
  dbrt_panel_model panel_u (.sys_clk, .buttonIn);
  task automatic chk(input string nm, input int exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp[31:0])
    begin
      fails++;
      $display("[ERR] %s exp %0d got %0d", nm, exp, got);
    end
  endtask
  task automatic chkRng(input string nm, input int lo, input int hi, input logic [31:0] got);
    cmpCount++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      fails++;
      $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask
  task automatic stopTest();
    $display("compares %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input int exp);
    @(posedge sys_clk);
    regAddr <= a;
    repeat (2) @(negedge sys_clk);
    chk("rdata", exp, regRdata_r);
  endtask
  task automatic waitLvl(input int lvl, input int lim, output int c);
    for (c = 0; c < lim && backlightLevel_r !== lvl[3:0]; c++)
      @(negedge sys_clk);
    chk("backlight", lvl, {28'h0, backlightLevel_r});
    if (c == lim)
      stopTest();
  endtask
  task automatic clr();
    @(posedge sys_clk);
    compRunClear <= 1'b1;
    repeat (3) @(posedge sys_clk);
    compRunClear <= 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    #400000;
    fails++;
    stopTest();
  end
  initial
  begin
    {rst_n, identifyReq, measuringActive, compRunClear, regWrite} = 5'h0;
    {compViolation, phaseSeq, timeSelect, regAddr, regWdata} = 53'h0;
    void'($urandom(32'hafff7e5a));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("contrast", 5, lcdContrast_r);
    chk("backlight", 6, backlightLevel_r);
    rd(10'h023, 5);
    rd(10'h024, 6);
    rd(10'h2ea, 900);
    rd(10'h2eb, 0);
    rd(10'h2ee, 100);
    rd(10'h2f2, 100000);
    $display("test reset values end");
    j = $urandom_range(9);
    wr(10'h023, j);
    rd(10'h023, j);
    wr(10'h023, 12);
    rd(10'h023, 9);
    wr(10'h2ee, 7);
    rd(10'h2ee, 100);
    wr(10'h2f2, 7);
    rd(10'h2f2, 100000);
    wr(10'h2ea, 10);
    rd(10'h2ea, 60);
    rd(10'h100, 0);
    chk("contrast", 9, lcdContrast_r);
    $display("test register writes end");
    wr(10'h024, 7);
    opl = 7;
    wr(10'h2eb, 2);
    panel_u.press($urandom_range(2), 3 + $urandom_range(17));
    waitLvl(opl, 20, n);
    waitLvl(2, 800, n);
    chkRng("standby delay", 570, 620, n);
    panel_u.press($urandom_range(2), 3);
    waitLvl(opl, 20, n);
    $display("test standby end");
    @(posedge sys_clk);
    identifyReq <= 1'b1;
    nine = 0;
    zero = 0;
    repeat (60)
    begin
      @(negedge sys_clk);
      nine += (backlightLevel_r === 4'h9);
      zero += (backlightLevel_r === 4'h0);
    end
    chkRng("flash max", 5, 60, nine);
    chkRng("flash min", 5, 60, zero);
    chkRng("flash other", 0, 4, 60 - nine - zero);
    @(posedge sys_clk);
    identifyReq <= 1'b0;
    waitLvl(opl, 30, n);
    $display("test identify end");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      phaseSeq <= k[1:0];
      repeat (4) @(negedge sys_clk);
      p0 = rotationPos_r;
      repeat (20) @(negedge sys_clk);
      chk("rotation dir", (k == 3) ? 0 : k, rotationDir_r);
      chk("rotation step", (k == 1) ? 2 : (k == 2) ? 4 : 0, (rotationPos_r - p0 + 6) % 6);
    end
    $display("test rotation end");
    j = $urandom_range(5);
    @(posedge sys_clk);
    compViolation[j] <= 1'b1;
    timeSelect <= 3'(j + 1);
    repeat (20 * TICK) @(posedge sys_clk);
    compViolation <= 6'h0;
    repeat (6) @(negedge sys_clk);
    chkRng("comp run", 19, 21, timeValue_r);
    chk("hours flag", 0, timeInHours_r);
    @(posedge sys_clk);
    timeSelect <= 3'((j + 1) % 6 + 1);
    repeat (4) @(negedge sys_clk);
    chk("comp run other", 0, timeValue_r);
    @(posedge sys_clk);
    timeSelect <= 3'(j + 1);
    clr();
    chk("comp run cleared", 0, timeValue_r);
    $display("test comparator end");
    @(posedge sys_clk);
    measuringActive <= 1'b1;
    timeSelect <= 3'h0;
    repeat (370 * TICK) @(posedge sys_clk);
    measuringActive <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("op hours", 1, timeValue_r);
    chk("hours flag", 1, timeInHours_r);
    clr();
    chk("op hours kept", 1, timeValue_r);
    $display("test operating hours end");
    stopTest();
  end
endmodule // testbench
